// ===== logic/ccol_pkg.sv
// ccol_pkg: constants, source codes and carriers for the camera output line select block
// assumes a 100 MHz system clock and a 32-bit AHB-Lite register bus
package ccol_pkg;

  // ==========================================
  // clock and timing
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned PPS_PERIOD_NS  = 1000000000;
  localparam int unsigned PPS_HALF_CYC   = PPS_PERIOD_NS / 2 / CLK_PERIOD_NS;
  localparam int unsigned BLINK_HALF_NS  = 50000000;
  localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_NS / CLK_PERIOD_NS;
  localparam int unsigned DEB_CYC        = 16;
  localparam int unsigned TRIG_DLY_CYC   = 4;

  // ==========================================
  // register map (byte addresses, word aligned)
  localparam logic [7:0] ADDR_SEL    = 8'h00;
  localparam logic [7:0] ADDR_USER   = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;

  // select register fields
  localparam int unsigned SEL_ISO_LSB = 0;
  localparam int unsigned SEL_OC_LSB  = 8;
  localparam int unsigned SEL_OC_DIR  = 16;
  // user register fields
  localparam int unsigned USR_OUT1 = 0;
  localparam int unsigned USR_OUT2 = 1;
  localparam int unsigned USR_SW0  = 2;
  localparam int unsigned USR_SW1  = 3;
  // status register fields
  localparam int unsigned ST_ISO_OUT = 0;
  localparam int unsigned ST_OC_OUT  = 1;
  localparam int unsigned ST_ISO_IN  = 2;
  localparam int unsigned ST_OC_IN   = 3;
  localparam int unsigned ST_GIG     = 4;
  localparam int unsigned ST_ACT     = 5;

  // ==========================================
  // source codes, one per selectable signal
  typedef enum logic [3:0] {
    SRC_FRAME_WAIT = 4'h0,
    SRC_FRAME_INT  = 4'h1,
    SRC_EXPOSURE   = 4'h2,
    SRC_ACQ_WAIT   = 4'h3,
    SRC_ACQ_INT    = 4'h4,
    SRC_READOUT    = 4'h5,
    SRC_DEB_ISO    = 4'h6,
    SRC_DEB_OC     = 4'h7,
    SRC_USER1      = 4'h8,
    SRC_USER2      = 4'h9,
    SRC_TIMER0     = 4'hA,
    SRC_SW0        = 4'hB,
    SRC_SW1        = 4'hC,
    SRC_LOGIC0     = 4'hD,
    SRC_PPS        = 4'hE
  } ccol_src_t;

  localparam logic [31:0] SEL_RESET = 32'h0000_0000;

  // ==========================================
  // carriers
  typedef struct packed {
    logic exposure_active;      // high during exposure
    logic image_out_done;       // pulse when the image has left the sensor path
    logic trigger_accepted;     // pulse when a trigger is accepted
    logic transfer_busy;        // high while an image goes to the host
    logic transfer_start;       // pulse at start of a host transfer
    logic sensor_frame_active;  // high during readout
    logic timer0_active;
    logic logic_block0;
  } ccol_stat_t;

  typedef struct packed {
    logic link_up;
    logic link_gigabit;
    logic link_activity;
  } ccol_link_t;

endpackage

// ===== logic/ccol_tick.sv
// ccol_tick: pulse-per-second square wave and indicator blink phase
// assumes a free-running clock; ce freezes both dividers
`timescale 1ns/1ps
module ccol_tick #(
  parameter int unsigned PPS_HALF   = ccol_pkg::PPS_HALF_CYC,
  parameter int unsigned BLINK_HALF = ccol_pkg::BLINK_HALF_CYC
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic ce,
  // outputs
  output logic      pps,
  output logic      blink
);
  import ccol_pkg::*;

  typedef struct packed {
    logic [31:0] pps_cnt;
    logic [31:0] blink_cnt;
    logic        pps;
    logic        blink;
  } ccol_tick_st_t;

  ccol_tick_st_t st_q;
  ccol_tick_st_t st_d;

  // ==========================================
  // dividers: equal high and low halves give the 50 percent duty
  always_comb begin
    st_d = st_q;
    if (st_q.pps_cnt == 32'(PPS_HALF - 1)) begin
      st_d.pps_cnt = 32'h0000_0000;
      st_d.pps     = ~st_q.pps;
    end else begin
      st_d.pps_cnt = st_q.pps_cnt + 32'h0000_0001;
    end
    if (st_q.blink_cnt == 32'(BLINK_HALF - 1)) begin
      st_d.blink_cnt = 32'h0000_0000;
      st_d.blink     = ~st_q.blink;
    end else begin
      st_d.blink_cnt = st_q.blink_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign pps   = st_q.pps;
  assign blink = st_q.blink;

endmodule

// ===== logic/ccol_top.sv
// ccol_top: source select for the isolated output line and the open-collector line, plus link indicators
// assumes status inputs come from logic on clk_sys; line and link inputs are asynchronous pins
//
// What this block does
// - Each of the two output lines has a selector among fifteen sources.
// - After reset both selectors choose frame trigger wait.
// - Frame trigger wait is low from exposure start until image output.
// - Frame trigger internal is the accepted trigger delayed by processing delay.
// - Exposure active is high throughout exposure, low after it.
// - Acquisition trigger wait is low while an image transfers to host.
// - Acquisition trigger internal marks the start of each host transfer.
// - Sensor readout source is the sensor frame active level.
// - Two sources carry the debounced isolated input and open-collector input.
// - Two user sources drive a software-chosen static level.
// - Timer active source follows the timer zero output.
// - Two software signal sources follow the two software signal channels.
// - Logic block source follows logic block zero.
// - Pulse-per-second source is a 1 Hz square wave, 50 percent duty.
// - Green indicator on at gigabit; yellow blinks during transfer.
// - At 100 megabit green stays off; yellow off when not transferring.
// - The open-collector line is configurable as input or output.
`timescale 1ns/1ps
module ccol_top #(
  parameter int unsigned PPS_HALF   = ccol_pkg::PPS_HALF_CYC,
  parameter int unsigned BLINK_HALF = ccol_pkg::BLINK_HALF_CYC,
  parameter int unsigned DEB        = ccol_pkg::DEB_CYC,
  parameter int unsigned TRIG_DLY   = ccol_pkg::TRIG_DLY_CYC
) (
  // clock, reset, enable
  input  wire logic               clk_sys,
  input  wire logic               reset_n,
  input  wire logic               ce,
  // ahb-lite slave
  input  wire logic               hsel,
  input  wire logic [7:0]         haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic      [31:0]        hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  // internal camera status
  input  wire ccol_pkg::ccol_stat_t stat,
  // link status pins from the phy
  input  wire ccol_pkg::ccol_link_t link,
  // line pins
  input  wire logic               isolated_input_line,
  output logic                    isolated_output_line,
  input  wire logic               open_collector_line_i,
  output logic                    open_collector_line_o,
  output logic                    open_collector_line_oe_n,
  // indicators
  output logic                    led_green,
  output logic                    led_yellow
);
  import ccol_pkg::*;

  localparam int unsigned DW = $clog2(DEB + 1);

  typedef struct packed {
    logic [3:0]          iso_sel;
    logic [3:0]          oc_sel;
    logic                oc_dir;      // 1 = output
    logic [3:0]          user;
    logic [1:0]          sync1;       // first stage, lines
    logic [1:0]          sync2;
    ccol_link_t          lsync1;      // first stage, link
    ccol_link_t          lsync2;
    logic [1:0][DW-1:0]  deb_cnt;
    logic [1:0]          deb;
    logic [TRIG_DLY-1:0] trig_sh;
    logic                expo_q;
    logic                frame_wait;
    logic                iso_out;
    logic                oc_out;
    logic                oc_oe_n;     // low = pulling the wire low
    logic                green;
    logic                yellow;
    logic                wr_pend;
    logic [7:0]          wr_addr;
    logic [31:0]         rdata;
    logic                ready;
  } ccol_st_t;

  ccol_st_t st_q;
  ccol_st_t st_d;
  logic     pps;
  logic     blink;
  logic [14:0] src_vec;

  // ==========================================
  // dividers for pulse-per-second and blink
  ccol_tick #(
    .PPS_HALF   (PPS_HALF),
    .BLINK_HALF (BLINK_HALF)
  ) u_tick (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .ce      (ce),
    .pps     (pps),
    .blink   (blink)
  );

  // ==========================================
  // source mux; codes outside the table give the inactive level
  function automatic logic pick(input logic [3:0] code, input logic [14:0] v);
    logic r;
    r = 1'b0;
    if (code <= SRC_PPS) begin
      r = v[code];
    end
    return r;
  endfunction

  // address decode shared by read and write paths
  function automatic logic [1:0] decode(input logic [7:0] a);
    logic [1:0] r;
    r = 2'h3;
    case (a)
      ADDR_SEL:    r = 2'h0;
      ADDR_USER:   r = 2'h1;
      ADDR_STATUS: r = 2'h2;
      default:     r = 2'h3;
    endcase
    return r;
  endfunction

  // ==========================================
  // source vector, one bit per code
  always_comb begin
    src_vec                 = '0;
    src_vec[SRC_FRAME_WAIT] = st_q.frame_wait;
    src_vec[SRC_FRAME_INT]  = st_q.trig_sh[TRIG_DLY-1];
    src_vec[SRC_EXPOSURE]   = stat.exposure_active;
    src_vec[SRC_ACQ_WAIT]   = ~stat.transfer_busy;
    src_vec[SRC_ACQ_INT]    = stat.transfer_start;
    src_vec[SRC_READOUT]    = stat.sensor_frame_active;
    src_vec[SRC_DEB_ISO]    = st_q.deb[0];
    src_vec[SRC_DEB_OC]     = st_q.deb[1];
    src_vec[SRC_USER1]      = st_q.user[USR_OUT1];
    src_vec[SRC_USER2]      = st_q.user[USR_OUT2];
    src_vec[SRC_TIMER0]     = stat.timer0_active;
    src_vec[SRC_SW0]        = st_q.user[USR_SW0];
    src_vec[SRC_SW1]        = st_q.user[USR_SW1];
    src_vec[SRC_LOGIC0]     = stat.logic_block0;
    src_vec[SRC_PPS]        = pps;
  end

  // ==========================================
  // next state
  always_comb begin
    st_d = st_q;

    // pins pass two flops before anything reads them
    st_d.sync1  = {open_collector_line_i, isolated_input_line};
    st_d.sync2  = st_q.sync1;
    st_d.lsync1 = link;
    st_d.lsync2 = st_q.lsync1;

    // debounce: a level must hold DEB cycles before it is accepted;
    // an open-collector line driven by us still reads back, which is harmless
    for (int i = 0; i < 2; i++) begin
      if (st_q.sync2[i] == st_q.deb[i]) begin
        st_d.deb_cnt[i] = '0;
      end else if (st_q.deb_cnt[i] == DW'(DEB - 1)) begin
        st_d.deb_cnt[i] = '0;
        st_d.deb[i]     = st_q.sync2[i];
      end else begin
        st_d.deb_cnt[i] = st_q.deb_cnt[i] + DW'(1);
      end
    end

    // accepted trigger delayed by a fixed pipeline
    st_d.trig_sh = {st_q.trig_sh[TRIG_DLY-2:0], stat.trigger_accepted};

    // frame wait drops at exposure start, rises when the image is out
    st_d.expo_q = stat.exposure_active;
    if (stat.exposure_active && !st_q.expo_q) begin
      st_d.frame_wait = 1'b0;
    end else if (stat.image_out_done) begin
      st_d.frame_wait = 1'b1;
    end

    // registered selection: no decode glitch reaches a pin
    st_d.iso_out = pick(st_q.iso_sel, src_vec);
    st_d.oc_out  = pick(st_q.oc_sel, src_vec);

    // indicators
    // fields by name: the packed order puts link_up in the top bit
    st_d.green  = st_q.lsync2.link_up & st_q.lsync2.link_gigabit;
    st_d.yellow = st_q.lsync2.link_activity & blink;

    // ahb: address phase sets up, data phase writes; reads answer in the data phase
    st_d.ready   = 1'b1;
    st_d.wr_pend = 1'b0;
    if (st_q.wr_pend) begin
      case (decode(st_q.wr_addr))
        2'h0: begin
          st_d.iso_sel = hwdata[SEL_ISO_LSB +: 4];
          st_d.oc_sel  = hwdata[SEL_OC_LSB +: 4];
          st_d.oc_dir  = hwdata[SEL_OC_DIR];
        end
        2'h1: st_d.user = hwdata[3:0];
        default: ;
      endcase
    end
    if (hsel && hready && htrans[1]) begin
      st_d.wr_pend = hwrite;
      st_d.wr_addr = haddr;
      st_d.rdata   = 32'h0000_0000;
      if (!hwrite) begin
        case (decode(haddr))
          2'h0: begin
            st_d.rdata[SEL_ISO_LSB +: 4] = st_q.iso_sel;
            st_d.rdata[SEL_OC_LSB +: 4]  = st_q.oc_sel;
            st_d.rdata[SEL_OC_DIR]       = st_q.oc_dir;
          end
          2'h1: st_d.rdata[3:0] = st_q.user;
          2'h2: begin
            st_d.rdata[ST_ISO_OUT] = st_q.iso_out;
            st_d.rdata[ST_OC_OUT]  = st_q.oc_out;
            st_d.rdata[ST_ISO_IN]  = st_q.deb[0];
            st_d.rdata[ST_OC_IN]   = st_q.deb[1];
            st_d.rdata[ST_GIG]     = st_q.lsync2.link_gigabit;
            st_d.rdata[ST_ACT]     = st_q.lsync2.link_activity;
          end
          default: st_d.rdata = 32'h0000_0000;
        endcase
      end
    end

    // pin enable from the next direction and level, so the enable leaves a flop
    // in the same cycle as the level it stands for
    st_d.oc_oe_n = ~(st_d.oc_dir & ~st_d.oc_out);
  end

  // ==========================================
  // state register; reset selects frame trigger wait on both lines
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      st_q            <= '0;
      st_q.iso_sel    <= SRC_FRAME_WAIT;
      st_q.oc_sel     <= SRC_FRAME_WAIT;
      st_q.frame_wait <= 1'b1;
      st_q.ready      <= 1'b1;
      st_q.oc_oe_n    <= 1'b1; // line released while an input
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  // ==========================================
  // outputs straight from state flops, except hresp and open_collector_line_o, which are constant
  assign hrdata                = st_q.rdata;
  assign hreadyout             = st_q.ready;
  assign hresp                 = 1'b0;
  assign isolated_output_line  = st_q.iso_out;
  // open collector only pulls low; a high level releases the line
  assign open_collector_line_o    = 1'b0;
  assign open_collector_line_oe_n = st_q.oc_oe_n;
  assign led_green             = st_q.green;
  assign led_yellow            = st_q.yellow;

  // ==========================================
  // checks; every line is one flop behind its source, so the checks
  // compare with sampled values of the cycle before
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // ==========================================
  // selection, register writes and reset
  sel_follow_a : assert property (ce |=> isolated_output_line == $past(pick(st_q.iso_sel, src_vec)))
    else $error("isolated line does not follow its selected source");
  oc_follow_a : assert property (ce |=> st_q.oc_out == $past(pick(st_q.oc_sel, src_vec)))
    else $error("open-collector source not taken at the next edge");
  sel_write_a : assert property (ce && st_q.wr_pend && decode(st_q.wr_addr) == 2'h0
                                 |=> st_q.iso_sel == $past(hwdata[SEL_ISO_LSB +: 4]))
    else $error("select write did not land");
  dir_write_a : assert property (ce && st_q.wr_pend && decode(st_q.wr_addr) == 2'h0
                                 |=> st_q.oc_dir == $past(hwdata[SEL_OC_DIR]))
    else $error("direction write did not land");
  reset_sel_a : assert property ($rose(reset_n) |-> st_q.iso_sel == SRC_FRAME_WAIT
                                   && st_q.oc_sel == SRC_FRAME_WAIT)
    else $error("selectors not at frame trigger wait after reset");
  bad_code_a : assert property (ce && st_q.iso_sel == 4'hF |=> !isolated_output_line)
    else $error("unsupported code drove the line active");

  // ==========================================
  // sources with logic of their own
  frame_wait_a : assert property (ce && stat.exposure_active && !st_q.expo_q |=> !st_q.frame_wait)
    else $error("frame wait did not drop at exposure start");
  frame_set_a : assert property (ce && stat.image_out_done && !(stat.exposure_active && !st_q.expo_q)
                                 |=> st_q.frame_wait)
    else $error("frame wait did not rise when the image was out");
  trig_delay_a : assert property (ce [*8] ##0 $past(stat.trigger_accepted, TRIG_DLY)
                                  |-> st_q.trig_sh[TRIG_DLY-1])
    else $error("delayed trigger missing");
  deb_hold_a : assert property (ce && st_q.deb_cnt[0] != DW'(DEB - 1)
                                |=> st_q.deb[0] == $past(st_q.deb[0]))
    else $error("debounced input moved before its hold time");
  user_write_a : assert property (ce && st_q.wr_pend && decode(st_q.wr_addr) == 2'h1
                                  |=> st_q.user == $past(hwdata[3:0]))
    else $error("user level write did not land");

  // ==========================================
  // open-collector direction
  oc_input_a : assert property (!st_q.oc_dir |-> open_collector_line_oe_n)
    else $error("open-collector line driven while an input");
  oc_drive_a : assert property (ce |=> open_collector_line_oe_n == !(st_q.oc_dir && !st_q.oc_out))
    else $error("open-collector enable does not match direction and level");

  // ==========================================
  // indicators: two sync flops and one output flop behind the link pins
  green_a : assert property (ce [*4] |-> led_green == ($past(link.link_up, 3)
                             && $past(link.link_gigabit, 3)))
    else $error("green indicator does not match gigabit link");
  green_slow_a : assert property (ce [*4] ##0 !$past(link.link_gigabit, 3) |-> !led_green)
    else $error("green lit below gigabit");
  yellow_blink_a : assert property (ce [*4] ##0 $past(link.link_activity, 3)
                                    |-> led_yellow == $past(blink))
    else $error("yellow does not follow the blink phase during transfer");
  yellow_idle_a : assert property (ce [*4] ##0 !$past(link.link_activity, 3) |-> !led_yellow)
    else $error("yellow lit without activity");

endmodule

// ===== dv/ccol_strobe_model.sv
// ccol_strobe_model: external strobe unit and controller wired to both output lines
// assumes the bench supplies clk_sys and says when the controller pulls the wire low
`timescale 1ns/1ps
module ccol_strobe_model (
  // clock and counter clear
  input  wire logic  clk_sys,
  input  wire logic  clr,
  // lines from the camera
  input  wire logic  iso_line,
  input  wire logic  oc_oe_n,
  // controller side
  input  wire logic  pull_low,
  output logic       oc_wire,
  output int unsigned n_rise,
  output int unsigned n_high
);
  logic last_q = 1'b0;

  // ==========================================
  // wire
  // wired-and with pull-up: a released wire reads high, never a stale value
  assign oc_wire = ~(~oc_oe_n | pull_low);

  // ==========================================
  // strobe counters
  // rise and high counts let the bench judge rate and duty without edge races
  always @(posedge clk_sys) begin
    if (clr) begin
      n_rise <= 0;
      n_high <= 0;
    end else begin
      n_rise <= n_rise + {31'h0, iso_line & ~last_q};
      n_high <= n_high + {31'h0, iso_line};
    end
    last_q <= iso_line;
  end
endmodule

// ===== dv/ccol_top_tb_top.sv
// ccol_top_tb_top: self-checking bench for the output line select block
// assumes shortened dividers (pps half 8, blink half 4, debounce 2); ce high except one freeze check
`timescale 1ns/1ps
module ccol_top_tb_top;
  import ccol_pkg::*;
  localparam ccol_src_t LV_SRC [5] = '{SRC_EXPOSURE, SRC_ACQ_WAIT, SRC_READOUT, SRC_TIMER0, SRC_LOGIC0};
  localparam int        LV_BIT [5] = '{7, 4, 2, 1, 0};
  localparam ccol_src_t US_SRC [4] = '{SRC_USER1, SRC_USER2, SRC_SW0, SRC_SW1};
  logic        clk_sys, reset_n, hsel, hwrite, hreadyout, hresp, iso_in, iso_out;
  logic        oc_o, oc_oe_n, oc_wire, led_g, led_y, pull_low, clr, chk, ce;
  logic        rd_pend = 1'b0;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [31:0] hwdata, hrdata, u;
  ccol_stat_t  stat;
  ccol_link_t  link;
  int unsigned n_rise, n_high, mismatches, n_compared;
  logic [34:0] q[$];

  // ==========================================
  // clock, design and far side
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  ccol_top #(.PPS_HALF(8), .BLINK_HALF(4), .DEB(2), .TRIG_DLY(4)) uut (
    .clk_sys(clk_sys), .reset_n(reset_n), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .stat(stat), .link(link), .isolated_input_line(iso_in),
    .isolated_output_line(iso_out), .open_collector_line_i(oc_wire), .open_collector_line_o(oc_o),
    .open_collector_line_oe_n(oc_oe_n), .led_green(led_g), .led_yellow(led_y));
  ccol_strobe_model far (.clk_sys(clk_sys), .clr(clr), .iso_line(iso_out), .oc_oe_n(oc_oe_n),
    .pull_low(pull_low), .oc_wire(oc_wire), .n_rise(n_rise), .n_high(n_high));

  // ==========================================
  // reporting
  task automatic summarize();
    if (mismatches == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one selector for every observable; kind 6 is bus ready, 7 both strobe counts
  function automatic logic [31:0] obs_of(input logic [2:0] k);
    case (k)
      3'h0: return hrdata;
      3'h1: return {31'h0, iso_out};
      3'h2: return {31'h0, oc_wire};
      3'h3: return {30'h0, led_g, led_y};
      3'h4: return n_rise;
      3'h5: return n_high;
      3'h6: return {31'h0, hreadyout};
      default: return {n_rise[15:0], n_high[15:0]};
    endcase
  endfunction

  // ==========================================
  // monitor: pops the oldest note when a read completes or a sample is flagged
  always @(posedge clk_sys) begin
    logic [34:0] e;
    if (rd_pend || chk) begin
      e = q.pop_front();
      check(obs_of(e[34:32]), e[31:0]);
    end
    rd_pend <= hsel && htrans[1] && !hwrite && hreadyout;
  end

  // ==========================================
  // drivers
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wait_sig(input logic [2:0] k, input logic [31:0] v);
    int n;
    n = 0;
    while (obs_of(k) !== v) begin
      n++;
      if (n > 60) begin
        mismatches++;
        summarize();
      end
      @(posedge clk_sys);
    end
  endtask
  // master holds each phase until hready is seen high; no fixed latency assumed
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge clk_sys);
    wait_sig(3'h6, 32'h1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_sys);
    wait_sig(3'h6, 32'h1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    q.push_back({3'h0, exp});
    bus(1'b0, a, 32'h0);
  endtask
  task automatic look(input logic [2:0] k, input logic [31:0] v);
    q.push_back({k, v});
    chk <= 1'b1;
    @(posedge clk_sys);
    chk <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic sel(input logic [3:0] iso, input logic [3:0] oc, input logic dir);
    bus(1'b1, ADDR_SEL, (32'(dir) << SEL_OC_DIR) | (32'(oc) << SEL_OC_LSB) | 32'(iso));
    tick(2);
  endtask
  task automatic pulse_seen(input int b);
    stat[b] <= 1'b1;
    @(posedge clk_sys);
    stat[b] <= 1'b0;
    wait_sig(3'h1, 32'h1);
    tick(2);
  endtask

  // ==========================================
  // main sequence
  initial begin
    reset_n = 1'b0; hsel = 1'b0; haddr = 8'h00; htrans = 2'h0; hwrite = 1'b0; hwdata = 32'h0;
    stat = '0; link = '0; iso_in = 1'b0; pull_low = 1'b0; clr = 1'b1; chk = 1'b0; ce = 1'b1;
    mismatches = 0;
    n_compared = 0;
    u = $urandom(10092);
    tick(16);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    rd(ADDR_SEL, SEL_RESET);
    rd(8'h0C, 32'h0);
    tick(2);
    look(3'h1, 32'h1);
    look(3'h2, 32'h1);
    stat.exposure_active <= 1'b1;
    tick(3);
    stat.exposure_active <= 1'b0;
    tick(3);
    look(3'h1, 32'h0);
    stat.image_out_done <= 1'b1;
    @(posedge clk_sys);
    stat.image_out_done <= 1'b0;
    tick(3);
    look(3'h1, 32'h1);
    foreach (LV_SRC[i]) begin
      sel(LV_SRC[i], SRC_FRAME_WAIT, 1'b0);
      for (int v = 0; v < 2; v++) begin
        stat[LV_BIT[i]] <= v[0];
        tick(3);
        look(3'h1, {31'h0, v[0] ^ (LV_SRC[i] == SRC_ACQ_WAIT)});
      end
      stat <= '0;
    end
    sel(SRC_FRAME_INT, SRC_FRAME_WAIT, 1'b0);
    pulse_seen(5);
    look(3'h1, 32'h0);
    sel(SRC_ACQ_INT, SRC_FRAME_WAIT, 1'b0);
    pulse_seen(3);
    look(3'h1, 32'h0);
    for (int r = 0; r < 4; r++) begin
      u = $urandom() & 32'hF;
      bus(1'b1, ADDR_USER, u);
      rd(ADDR_USER, u);
      foreach (US_SRC[c]) begin
        sel(US_SRC[c], SRC_FRAME_WAIT, 1'b0);
        look(3'h1, {31'h0, u[c]});
      end
    end
    sel(4'hF, SRC_FRAME_WAIT, 1'b0);
    look(3'h1, 32'h0);
    bus(1'b1, ADDR_USER, 32'h3);
    sel(SRC_USER1, SRC_FRAME_WAIT, 1'b0);
    clr <= 1'b0;
    sel(SRC_USER2, SRC_FRAME_WAIT, 1'b0);
    look(3'h4, 32'h0);
    look(3'h1, 32'h1);
    clr <= 1'b1;
    // with ce low the write is not taken and the user level must stay
    ce <= 1'b0;
    bus(1'b1, ADDR_USER, 32'h0);
    ce <= 1'b1;
    tick(2);
    look(3'h1, 32'h1);
    sel(SRC_DEB_ISO, SRC_FRAME_WAIT, 1'b0);
    iso_in <= 1'b1;
    @(posedge clk_sys);
    iso_in <= 1'b0;
    tick(8);
    look(3'h1, 32'h0);
    iso_in <= 1'b1;
    tick(8);
    look(3'h1, 32'h1);
    sel(SRC_DEB_OC, SRC_FRAME_WAIT, 1'b0);
    pull_low <= 1'b1;
    tick(8);
    look(3'h1, 32'h0);
    pull_low <= 1'b0;
    tick(8);
    look(3'h1, 32'h1);
    bus(1'b1, ADDR_USER, 32'h0);
    sel(SRC_FRAME_WAIT, SRC_USER2, 1'b1);
    look(3'h2, 32'h0);
    bus(1'b1, ADDR_USER, 32'h2);
    tick(3);
    look(3'h2, 32'h1);
    bus(1'b1, ADDR_USER, 32'h0);
    sel(SRC_FRAME_WAIT, SRC_USER2, 1'b0);
    look(3'h2, 32'h1);
    sel(SRC_PPS, SRC_FRAME_WAIT, 1'b0);
    clr <= 1'b0;
    tick(160);
    clr <= 1'b1;
    // both counts in one sample, before the clear lands
    look(3'h7, 32'h000A_0050);
    link <= 3'b110;
    tick(6);
    look(3'h3, 32'h2);
    link <= 3'b111;
    wait_sig(3'h3, 32'h3);
    wait_sig(3'h3, 32'h2);
    look(3'h3, 32'h2);
    link <= 3'b101;
    wait_sig(3'h3, 32'h1);
    wait_sig(3'h3, 32'h0);
    link <= 3'b100;
    tick(10);
    look(3'h3, 32'h0);
    summarize();
  end
endmodule
